// >>> bcd_bridge_ctrl.sv
// Bridge control doubleword, discard timers and expiry reporting
// Function
// - VGA enable forces downstream forwarding
// - Bits 20 and 31:28 read zero
// - Abort mode 0: all-ones reads, drop writes
// - Abort mode 1: target abort, else system error
// - Bit 22 holds secondary reset asserted
// - Bit 23 permits secondary fast back-to-back
// - Primary timer limit by bit 24
// - Secondary timer limit by bit 25
// - Bit 26 sticky expiry, write one clears
// - Bit 27 routes expiry to system error
// - Control occupies upper half at 3Ch
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module bcd_bridge_ctrl #(
  parameter int LONG_CYCLES = bcd_pkg::LONG_CYCLES,
  parameter int SHORT_CYCLES = bcd_pkg::SHORT_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic [bcd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [bcd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Address window decode
  input wire logic vga_addr_hit,
  input wire logic window_hit,
  output logic forward_downstream,
  // Master abort handling
  input wire logic ma_event,
  input wire logic ma_is_read,
  input wire logic ta_possible,
  input wire logic serr_enable,
  output logic [31:0] ma_read_data,
  output logic ma_drop_write,
  output logic ma_target_abort,
  // Secondary bus control
  output logic secondary_reset_assert,
  output logic fast_b2b_enable,
  // Delayed transactions, primary and secondary
  input wire logic pri_dly_queued,
  input wire logic pri_dly_taken,
  input wire logic sec_dly_queued,
  input wire logic sec_dly_taken,
  output logic pri_dly_discard,
  output logic sec_dly_discard,
  // System error and interrupt
  output logic primary_system_error_out,
  output logic irq
);

  logic [31:0] ctrl;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic aw_held;
  logic w_held;
  logic [bcd_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic [31:0] wr_bits;
  logic pri_exp;
  logic sec_exp;
  logic any_exp;
  logic ar_fire;

  bcd_timer_if pri_if ();
  bcd_timer_if sec_if ();

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  function automatic logic mapped(input logic [bcd_pkg::ADDR_W-1:0] a);
    mapped = a == bcd_pkg::CTRL_OFF || a == bcd_pkg::IRQ_STAT_OFF || a == bcd_pkg::IRQ_MASK_OFF;
  endfunction : mapped

  // ----------------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------------
  assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_held && !s_axi_bvalid;
  assign do_write = ce && aw_held && w_held && !s_axi_bvalid;
  assign wr_bits = w_data & lane_mask(w_strb);
  assign wr_ctrl = do_write && aw_addr == bcd_pkg::CTRL_OFF;
  assign wr_stat = do_write && aw_addr == bcd_pkg::IRQ_STAT_OFF;
  assign wr_mask = do_write && aw_addr == bcd_pkg::IRQ_MASK_OFF;

  // Holding registers for address and data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, error for unmapped addresses
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bcd_pkg::RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? bcd_pkg::RESP_OKAY : bcd_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  // Read data mux, registered
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= bcd_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? bcd_pkg::RESP_OKAY : bcd_pkg::RESP_SLVERR;
        case (s_axi_araddr)
          bcd_pkg::CTRL_OFF: s_axi_rdata <= ctrl;
          bcd_pkg::IRQ_STAT_OFF: s_axi_rdata <= {30'h0, irq_stat};
          bcd_pkg::IRQ_MASK_OFF: s_axi_rdata <= {30'h0, irq_mask};
          default: s_axi_rdata <= '0;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control doubleword
  // ----------------------------------------------------------------------
  assign any_exp = pri_exp || sec_exp;

  // Read-write fields; reserved and read-only bits never stored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= bcd_pkg::CTRL_RESET;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl <= (ctrl & ~(lane_mask(w_strb) & bcd_pkg::CTRL_RW_MASK)) | (wr_bits & bcd_pkg::CTRL_RW_MASK);
      end
      // Sticky expiry status: a new expiry wins over the clear
      if (any_exp) begin
        ctrl[bcd_pkg::EXP_STAT_BIT] <= 1'b1;
      end else if (wr_ctrl && wr_bits[bcd_pkg::EXP_STAT_BIT]) begin
        ctrl[bcd_pkg::EXP_STAT_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= bcd_pkg::IRQ_RESET;
      irq_mask <= bcd_pkg::IRQ_RESET;
    end else if (ce) begin
      irq_stat <= (irq_stat & ~(wr_stat ? wr_bits[1:0] : 2'h0)) | {sec_exp, pri_exp};
      if (wr_mask) begin
        irq_mask <= (irq_mask & ~{2{w_strb[0]}}) | wr_bits[1:0];
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------------
  // Address forwarding and secondary bus controls
  // ----------------------------------------------------------------------
  assign forward_downstream = window_hit || (vga_addr_hit && ctrl[bcd_pkg::VGA_BIT]);
  assign secondary_reset_assert = ctrl[bcd_pkg::SEC_RST_BIT];
  assign fast_b2b_enable = ctrl[bcd_pkg::FBB_BIT];

  // ----------------------------------------------------------------------
  // Master abort response and system error
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ma_read_data <= '0;
      ma_drop_write <= 1'b0;
      ma_target_abort <= 1'b0;
      primary_system_error_out <= 1'b0;
    end else if (ce) begin
      ma_drop_write <= 1'b0;
      ma_target_abort <= 1'b0;
      primary_system_error_out <= 1'b0;
      if (ma_event && !ctrl[bcd_pkg::MA_MODE_BIT]) begin
        ma_read_data <= bcd_pkg::ABORT_DATA;
        ma_drop_write <= !ma_is_read;
      end
      if (ma_event && ctrl[bcd_pkg::MA_MODE_BIT]) begin
        ma_target_abort <= ta_possible;
        if (!ta_possible && serr_enable) begin
          primary_system_error_out <= 1'b1;
        end
      end
      if (any_exp && ctrl[bcd_pkg::EXP_SERR_BIT]) begin
        primary_system_error_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Discard timers
  // ----------------------------------------------------------------------
  assign pri_if.start = pri_dly_queued;
  assign pri_if.stop = pri_dly_taken;
  assign pri_if.short_sel = ctrl[bcd_pkg::PRI_SHORT_BIT];
  assign sec_if.start = sec_dly_queued;
  assign sec_if.stop = sec_dly_taken;
  assign sec_if.short_sel = ctrl[bcd_pkg::SEC_SHORT_BIT];
  assign pri_exp = pri_if.expire;
  assign sec_exp = sec_if.expire;
  assign pri_dly_discard = pri_if.expire;
  assign sec_dly_discard = sec_if.expire;

  // Primary side timer
  bcd_discard_timer #(
    .LONG_CYCLES(LONG_CYCLES),
    .SHORT_CYCLES(SHORT_CYCLES),
    .CNT_W(16)
  ) u_pri_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .tif(pri_if)
  );

  // Secondary side timer
  bcd_discard_timer #(
    .LONG_CYCLES(LONG_CYCLES),
    .SHORT_CYCLES(SHORT_CYCLES),
    .CNT_W(16)
  ) u_sec_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .tif(sec_if)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  vga_forward_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    vga_addr_hit && ctrl[bcd_pkg::VGA_BIT] |-> forward_downstream)
    else $error("VGA address not forwarded");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ar_fire && s_axi_araddr == bcd_pkg::CTRL_OFF |=> s_axi_rdata[20] == 1'b0 && s_axi_rdata[31:28] == 4'h0)
    else $error("reserved control bits read nonzero");
  abort_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && ma_event && !ctrl[bcd_pkg::MA_MODE_BIT] |=> ma_read_data == bcd_pkg::ABORT_DATA && !ma_target_abort)
    else $error("silent master abort misbehaved");
  abort_report_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && ma_event && ctrl[bcd_pkg::MA_MODE_BIT] && !ta_possible && serr_enable |=> primary_system_error_out)
    else $error("reported master abort gave no system error");
  sec_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && wr_ctrl && w_strb[2] |=> secondary_reset_assert == $past(w_data[bcd_pkg::SEC_RST_BIT]))
    else $error("secondary reset not asserted");
  fast_b2b_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fast_b2b_enable |-> $past(wr_ctrl) || $stable(ctrl[bcd_pkg::FBB_BIT]))
    else $error("fast back-to-back changed without a write");
  exp_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && any_exp |=> ctrl[bcd_pkg::EXP_STAT_BIT])
    else $error("expiry status not set");
  exp_serr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && any_exp && ctrl[bcd_pkg::EXP_SERR_BIT] |=> primary_system_error_out)
    else $error("expiry gave no system error");
  write_resp_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  stat_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && wr_ctrl && wr_bits[bcd_pkg::EXP_STAT_BIT] && !any_exp |=> !ctrl[bcd_pkg::EXP_STAT_BIT])
    else $error("expiry status not cleared");
  exp_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && !ma_event && !ctrl[bcd_pkg::EXP_SERR_BIT] |=> !primary_system_error_out)
    else $error("system error without cause");
  drop_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && ma_event && !ctrl[bcd_pkg::MA_MODE_BIT] |=> ma_drop_write == !$past(ma_is_read))
    else $error("silent abort write drop wrong");
  discard_free_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(pri_dly_discard && pri_if.running) && !(sec_dly_discard && sec_if.running))
    else $error("discarded entry still timed");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && !wr_mask && |({sec_exp, pri_exp} & irq_mask) |=> irq)
    else $error("unmasked expiry gave no interrupt");

endmodule : bcd_bridge_ctrl

// >>> bcd_pkg.sv
// Constants shared by the bridge control register bank and its discard timers
package bcd_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFF = 12'h03c;
  localparam logic [11:0] IRQ_STAT_OFF = 12'h080;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h084;

  // ----------------------------------------------------------------------
  // Control doubleword fields
  // ----------------------------------------------------------------------
  localparam int VGA_BIT = 19;
  localparam int RSV_LOW_BIT = 20;
  localparam int MA_MODE_BIT = 21;
  localparam int SEC_RST_BIT = 22;
  localparam int FBB_BIT = 23;
  localparam int PRI_SHORT_BIT = 24;
  localparam int SEC_SHORT_BIT = 25;
  localparam int EXP_STAT_BIT = 26;
  localparam int EXP_SERR_BIT = 27;
  localparam logic [31:0] CTRL_RW_MASK = 32'h0bef_00ff;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Interrupt bits, timing and bus answers
  // ----------------------------------------------------------------------
  localparam int IRQ_PRI = 0;
  localparam int IRQ_SEC = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam int LONG_CYCLES = 32768;
  localparam int SHORT_CYCLES = 1024;
  localparam logic [31:0] ABORT_DATA = 32'hffff_ffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : bcd_pkg

// >>> bcd_timer_if.sv
// Connection between the control bank and one discard timer
`timescale 1ns/1ns
interface bcd_timer_if;
  logic start;
  logic stop;
  logic short_sel;
  logic expire;
  logic running;

  modport ctl (output start, output stop, output short_sel, input expire, input running);
  modport tmr (input start, input stop, input short_sel, output expire, output running);
endinterface : bcd_timer_if

// >>> bcd_discard_timer.sv
// One delayed-transaction discard timer
`timescale 1ns/1ns
module bcd_discard_timer #(
  parameter int LONG_CYCLES = bcd_pkg::LONG_CYCLES,
  parameter int SHORT_CYCLES = bcd_pkg::SHORT_CYCLES,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Control side
  bcd_timer_if.tmr tif
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] limit_m1;

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  if (SHORT_CYCLES < 1 || SHORT_CYCLES > LONG_CYCLES || $clog2(LONG_CYCLES) > CNT_W) begin : g_chk
    $error("discard timer limits do not fit the counter");
  end

  // Last count before expiry for the selected range
  assign limit_m1 = tif.short_sel ? CNT_W'(SHORT_CYCLES - 1) : CNT_W'(LONG_CYCLES - 1);

  // ----------------------------------------------------------------------
  // Counter: start on queueing, stop on completion, expire at the limit
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tif.running <= 1'b0;
      tif.expire <= 1'b0;
    end else if (ce) begin
      tif.expire <= 1'b0;
      if (tif.start) begin
        count <= '0;
        tif.running <= 1'b1;
      end else if (tif.stop) begin
        tif.running <= 1'b0;
      end else if (tif.running) begin
        if (count == limit_m1) begin
          tif.running <= 1'b0;
          tif.expire <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  tmr_expiry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && tif.running && !tif.start && !tif.stop && count == limit_m1 |=> tif.expire && !tif.running)
    else $error("timer did not expire at its limit");
  tmr_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && tif.start |=> tif.running && count == '0 && !tif.expire)
    else $error("timer did not restart");

endmodule : bcd_discard_timer

// >>> bcd_initiator_model.sv
// Delayed-request initiator model for one side of the bridge
`timescale 1ns/1ns
module bcd_initiator_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bench commands
  input wire logic go,
  input wire logic [15:0] repeat_wait,
  // Bridge side
  input wire logic discard,
  output logic queued,
  output logic taken
);
  logic active;
  logic [15:0] cnt;

  // Queue once, repeat after the wait unless the bridge dropped the entry
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      queued <= 1'h0;
      taken <= 1'h0;
      active <= 1'h0;
      cnt <= 16'h0;
    end else begin
      queued <= go;
      taken <= 1'h0;
      if (go) begin
        cnt <= repeat_wait;
        active <= 1'h1;
      end else if (active) begin
        cnt <= cnt - 16'h1;
        if (discard) begin
          active <= 1'h0;
        end else if (cnt == 16'h1) begin
          taken <= 1'h1;
          active <= 1'h0;
        end
      end
    end
  end
endmodule : bcd_initiator_model

// >>> testbench.sv
// Self-checking bench for the bridge control bank and discard timers
`timescale 1ns/1ns
module testbench;
  localparam int LNG = 64;
  localparam int SHT = 16;
  typedef struct packed {logic [31:0] wr; logic [31:0] rd;} bcd_row_s;
  typedef struct packed {logic mode; logic rd; logic ta; logic se; logic [2:0] exp;} bcd_ma_s;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic ce = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, ma_read_data, rdv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [1:0] go = 2'h0;
  logic [2:0] fl;
  logic vga_addr_hit = 1'h1, window_hit = 1'h0, ma_event = 1'h0, ma_is_read = 1'h0, ta_possible = 1'h0;
  logic serr_enable = 1'h0;
  logic forward_downstream, ma_drop_write, ma_target_abort, secondary_reset_assert, fast_b2b_enable, irq;
  logic pri_dly_queued, pri_dly_taken, sec_dly_queued, sec_dly_taken, pri_dly_discard, sec_dly_discard;
  logic primary_system_error_out;
  logic [15:0] wt [2] = '{16'h0, 16'h0};
  int error_cnt = 0, checked = 0, cyc = 0;
  bcd_row_s rows [5] = '{'{32'hffff_ffff, 32'h0bef_00ff}, '{32'h0040_0000, 32'h0040_0000},
    '{32'h0088_0000, 32'h0088_0000}, '{32'h0010_00a5, 32'h0000_00a5}, '{32'hf000_ff00, 32'h0}};
  bcd_ma_s mas [5] = '{'{1'h0, 1'h1, 1'h0, 1'h0, 3'h0}, '{1'h0, 1'h0, 1'h0, 1'h0, 3'h4},
    '{1'h1, 1'h0, 1'h1, 1'h1, 3'h2}, '{1'h1, 1'h1, 1'h0, 1'h1, 3'h1}, '{1'h1, 1'h0, 1'h0, 1'h0, 3'h0}};

  bcd_bridge_ctrl #(.LONG_CYCLES(LNG), .SHORT_CYCLES(SHT)) DUT (.clk_sys, .rst_n, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .vga_addr_hit, .window_hit, .forward_downstream, .ma_event, .ma_is_read,
    .ta_possible, .serr_enable, .ma_read_data, .ma_drop_write, .ma_target_abort, .secondary_reset_assert,
    .fast_b2b_enable, .pri_dly_queued, .pri_dly_taken, .sec_dly_queued, .sec_dly_taken, .pri_dly_discard,
    .sec_dly_discard, .primary_system_error_out, .irq);
  bcd_initiator_model pri_m (.clk_sys, .rst_n, .go(go[0]), .repeat_wait(wt[0]), .discard(pri_dly_discard),
    .queued(pri_dly_queued), .taken(pri_dly_taken));
  bcd_initiator_model sec_m (.clk_sys, .rst_n, .go(go[1]), .repeat_wait(wt[1]), .discard(sec_dly_discard),
    .queued(sec_dly_queued), .taken(sec_dly_taken));

  // Clock and hang guard
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  // Each valid held until its ready is seen high at a rising edge, each ready until its valid, then released
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic b_d;
    b_d = 1'h0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b_d) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) begin
        b_d = 1'h1;
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic r_d;
    r_d = 1'h0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!r_d) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) begin
        r_d = 1'h1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
      end
    end
  endtask : axi_read

  // One master abort event, flags taken one cycle after it
  task automatic ma_hit(input bcd_ma_s m, output logic [2:0] f);
    @(posedge clk_sys);
    ma_event <= 1'h1;
    ma_is_read <= m.rd;
    ta_possible <= m.ta;
    serr_enable <= m.se;
    @(posedge clk_sys);
    ma_event <= 1'h0;
    #1 f = {ma_drop_write, ma_target_abort, primary_system_error_out};
  endtask : ma_hit

  // Start a delayed request; count edges from the start edge to the discard
  task automatic run_timer(input logic sec, input logic [15:0] w, input int exp_n, input logic serr_exp);
    int n;
    logic seen;
    n = 0;
    seen = 1'h0;
    @(posedge clk_sys);
    go[sec] <= 1'h1;
    wt[sec] <= w;
    @(posedge clk_sys);
    go[sec] <= 1'h0;
    @(posedge clk_sys);
    while (n < LNG + 20 && !seen) begin
      @(posedge clk_sys);
      #1 n++;
      seen = ((sec ? sec_dly_discard : pri_dly_discard) === 1'h1);
    end
    check(seen ? n : 0, exp_n);
    if (seen) begin
      @(posedge clk_sys);
      #1 check(32'(primary_system_error_out), 32'(serr_exp));
    end
  endtask : run_timer

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'h1;
    axi_read(bcd_pkg::CTRL_OFF, rdv, rsp);
    check(rdv, 32'h0);
    axi_read(bcd_pkg::IRQ_STAT_OFF, rdv, rsp);
    check(rdv, 32'h0);
    check(32'(secondary_reset_assert), 32'h0);
    $display("Test reset done");
    foreach (rows[i]) begin
      axi_write(bcd_pkg::CTRL_OFF, rows[i].wr, rsp);
      check(32'(rsp), 32'(bcd_pkg::RESP_OKAY));
      axi_read(bcd_pkg::CTRL_OFF, rdv, rsp);
      check(rdv, rows[i].rd);
      check(32'(secondary_reset_assert), 32'(rows[i].rd[22]));
      check(32'(fast_b2b_enable), 32'(rows[i].rd[23]));
      check(32'(forward_downstream), 32'(rows[i].rd[19]));
    end
    axi_write(12'h100, 32'hffff_ffff, rsp);
    check(32'(rsp), 32'(bcd_pkg::RESP_SLVERR));
    axi_read(12'h100, rdv, rsp);
    check({rdv[31:2], rsp}, 32'(bcd_pkg::RESP_SLVERR));
    $display("Test register rows done");
    foreach (mas[i]) begin
      axi_write(bcd_pkg::CTRL_OFF, 32'(mas[i].mode) << 21, rsp);
      ma_hit(mas[i], fl);
      check(32'(fl), 32'(mas[i].exp));
      if (i == 0) check(ma_read_data, bcd_pkg::ABORT_DATA);
    end
    $display("Test master abort done");
    ce <= 1'h0;
    ma_hit(mas[2], fl);
    check(32'({fl, s_axi_awready, s_axi_arready}), 32'h0);
    ce <= 1'h1;
    $display("Test clock enable done");
    axi_write(bcd_pkg::IRQ_MASK_OFF, 32'h3, rsp);
    axi_write(bcd_pkg::CTRL_OFF, 32'h0900_0000, rsp);
    run_timer(1'h0, 16'h0, SHT, 1'h1);
    axi_read(bcd_pkg::CTRL_OFF, rdv, rsp);
    check(rdv, 32'h0d00_0000);
    axi_read(bcd_pkg::IRQ_STAT_OFF, rdv, rsp);
    check(rdv, 32'h1);
    check(32'(irq), 32'h1);
    axi_write(bcd_pkg::IRQ_MASK_OFF, 32'h0, rsp);
    check(32'(irq), 32'h0);
    axi_write(bcd_pkg::CTRL_OFF, 32'h0d00_0000, rsp);
    axi_read(bcd_pkg::CTRL_OFF, rdv, rsp);
    check(rdv, 32'h0900_0000);
    axi_write(bcd_pkg::CTRL_OFF, 32'h0, rsp);
    axi_write(bcd_pkg::IRQ_MASK_OFF, 32'h3, rsp);
    run_timer(1'h1, 16'h0, LNG, 1'h0);
    axi_read(bcd_pkg::IRQ_STAT_OFF, rdv, rsp);
    check(rdv, 32'h3);
    check(32'(irq), 32'h1);
    axi_write(bcd_pkg::IRQ_STAT_OFF, 32'h3, rsp);
    axi_read(bcd_pkg::IRQ_STAT_OFF, rdv, rsp);
    check(rdv, 32'h0);
    check(32'(irq), 32'h0);
    axi_write(bcd_pkg::CTRL_OFF, 32'h0500_0000, rsp);
    run_timer(1'h0, 16'h8, 0, 1'h0);
    axi_read(bcd_pkg::CTRL_OFF, rdv, rsp);
    check(rdv, 32'h0100_0000);
    $display("Test discard timers done");
    axi_write(bcd_pkg::CTRL_OFF, 32'hffff_ffff, rsp);
    @(posedge clk_sys);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    axi_read(bcd_pkg::CTRL_OFF, rdv, rsp);
    check(rdv, 32'h0);
    check(32'(secondary_reset_assert), 32'h0);
    $display("Test second reset done");
    stop_test();
  end
endmodule : testbench
